// ---- src/fsptr_defines.vh ----
/*
  Constants for the flash self-programming target resolver: register byte
  offsets on the AHB-Lite slave, field positions, reset values and timing counts.
  Assumes inclusion by its bare name from the design file.
*/
`ifndef FSPTR_DEFINES_VH
`define FSPTR_DEFINES_VH

`define FSPTR_OFF_CONFIG      8'h00
`define FSPTR_OFF_COMMAND     8'h04
`define FSPTR_OFF_ADDR_LOW    8'h08
`define FSPTR_OFF_ADDR_HIGH   8'h0C
`define FSPTR_OFF_DATA        8'h10
`define FSPTR_OFF_STATUS      8'h14
`define FSPTR_OFF_CONTEXT     8'h18
`define FSPTR_OFF_RESULT      8'h1C

`define FSPTR_CFG_IAP_EN_BIT  6
`define FSPTR_CFG_RESET       8'h00
`define FSPTR_CFG_WMASK       8'h43

`define FSPTR_ST_BUSY_BIT     2
`define FSPTR_ST_LOCK_LSB     5

`define FSPTR_CTX_EXT_BIT     0
`define FSPTR_CTX_ORIGIN_BIT  1

`define FSPTR_BLOCK1_TOP      16'h2000

`define FSPTR_RES_DONE_BIT    0
`define FSPTR_RES_REFUSE_BIT  1
`define FSPTR_RES_BLOCK_BIT   2
`define FSPTR_RES_ADDR_LSB    8

`define FSPTR_OSC_START_CYC   4'h4
`define FSPTR_OP_CYC          8'h20
`define FSPTR_OSC_STOP_CYC    4'h2

`endif

// ---- src/fsptr_resolver.v ----
/*
  Flash self-programming control: resolves the physical target block of each
  command, drops commands written while disabled, refuses locked or self-targeting ones, and
  sequences the timing oscillator around the flash operation.
  Assumes an AHB-Lite master on the register side, the external clock as hclk,
  and a flash array that acknowledges each operation with flash_op_done.
*/
`include "fsptr_defines.vh"

//////////////////////////////////////////////////////////////////////////////
module fsptr_resolver (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        clk_en,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        external_access_pin,
  input  wire [15:0] fetch_pc,
  input  wire [2:0]  lock_bits,
  input  wire        flash_op_done,
  output reg         osc_enable,
  output reg         flash_op_start,
  output reg         flash_op_block,
  output reg  [15:0] flash_op_addr,
  output reg  [7:0]  flash_op_data,
  output reg  [6:0]  flash_op_cmd,
  output reg         fetch_block1
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_START = 3'h1;
  localparam [2:0] ST_RUN   = 3'h2;
  localparam [2:0] ST_STOP  = 3'h3;

  reg  [7:0]  flash_config_reg;
  reg  [7:0]  flash_command_reg;
  reg  [7:0]  flash_addr_low_reg;
  reg  [7:0]  flash_addr_high_reg;
  reg  [7:0]  flash_data_reg;
  reg  [1:0]  context_reg;
  reg  [31:0] result_reg;
  reg  [2:0]  state_reg;
  reg  [7:0]  count_reg;
  reg         wr_pend_reg;
  reg  [7:0]  wr_addr_reg;
  reg         rd_pend_reg;
  reg  [7:0]  rd_addr_reg;

  wire        busy      = (state_reg != ST_IDLE);
  wire        bank00    = (flash_config_reg[1:0] == 2'b00);
  wire [15:0] tgt_addr  = {flash_addr_high_reg, flash_addr_low_reg};
  wire        tgt_low   = (tgt_addr < `FSPTR_BLOCK1_TOP);
  wire        from_ext  = context_reg[`FSPTR_CTX_EXT_BIT];
  wire        from_b1   = context_reg[`FSPTR_CTX_ORIGIN_BIT];
  wire        addr_ok   = (htrans[1] && hsel && hready);
  wire [7:0]  wdat      = hwdata[7:0];

  //////////////////////////////////////////////////////////////////////////////
  // Target resolution. Logical addresses are 16 bits wide, so the full
  // 64 KByte window is covered by tgt_addr alone.
  reg  res_valid;
  reg  res_block;
  always @*
  begin
    res_valid = 1'b0;
    res_block = 1'b0;
    if (external_access_pin && !from_ext)
    begin
      if (bank00 && from_b1)
      begin
        res_valid = 1'b1;
        res_block = 1'b0;
      end
      else
      begin
        // Internal code is in block 0 here; only the low window reaches block 1.
        res_valid = tgt_low;
        res_block = 1'b1;
      end
    end
    else
    begin
      res_valid = 1'b1;
      res_block = bank00 ? tgt_low : 1'b0;
    end
  end

  // Lock levels per block. Level 000 leaves both blocks open and 010 lets
  // each block program the other. Levels 110 and 001 hard-lock block 1 but
  // still let code in block 1 program block 0. Every other level locks both.
  // Unknown patterns fall to the locked side, so a glitch never opens a block.
  reg locked_sel;
  always @*
  begin
    locked_sel = 1'b1;
    case (lock_bits)
      3'b000:  locked_sel = 1'b0;
      3'b010:  locked_sel = 1'b0;
      3'b110:  locked_sel = res_block;
      3'b001:  locked_sel = res_block;
      default: locked_sel = 1'b1;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bank overlay for instruction fetch. Block 1 is seen only with select 00.
  wire fetch_b1_next = bank00 && (fetch_pc < `FSPTR_BLOCK1_TOP);

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, write data captured in the data phase.
  // Each mailbox register sits in one aligned word, the result in bits 23:0, every other one in the low byte:
  //   0x00 configuration: bit 6 enable, bits 1:0 bank select.
  //   0x04 command: a write here launches the operation.
  //   0x08 and 0x0C target address, low and high byte.
  //   0x10 data byte for a program operation.
  //   0x14 status: bit 2 busy, bits 7:5 the lock levels.
  //   0x18 context: bit 0 issuing code external, bit 1 issuing code in block 1.
  //   0x1C result: bit 0 done, bit 1 refused, bit 2 block, bits 23:8 address.
  // Offsets outside this map read as zero and ignore writes.
  // The issuing code's location comes from software through the context
  // register, since the core does not hand over the fetch address of the
  // instruction that writes the command.
  wire [7:0] rd_sel = addr_ok ? {haddr[7:2], 2'b00} : rd_addr_reg;
  wire cmd_write = wr_pend_reg && (wr_addr_reg == `FSPTR_OFF_COMMAND);
  wire iap_en    = flash_config_reg[`FSPTR_CFG_IAP_EN_BIT];
  // A command written while busy or disabled is dropped silently.
  wire launch    = cmd_write && iap_en && !busy;
  wire go        = launch && res_valid && !locked_sel;

  reg [31:0] rd_mux;
  always @*
  begin
    case (rd_sel)
      `FSPTR_OFF_CONFIG:    rd_mux = {24'h000000, flash_config_reg};
      `FSPTR_OFF_COMMAND:   rd_mux = {24'h000000, flash_command_reg};
      `FSPTR_OFF_ADDR_LOW:  rd_mux = {24'h000000, flash_addr_low_reg};
      `FSPTR_OFF_ADDR_HIGH: rd_mux = {24'h000000, flash_addr_high_reg};
      `FSPTR_OFF_DATA:      rd_mux = {24'h000000, flash_data_reg};
      `FSPTR_OFF_STATUS:    rd_mux = {24'h000000, lock_bits, 2'b00, busy, 2'b00};
      `FSPTR_OFF_CONTEXT:   rd_mux = {30'h00000000, context_reg};
      `FSPTR_OFF_RESULT:    rd_mux = result_reg;
      default:              rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= 8'h00;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end
    else if (clk_en)
    begin
      wr_pend_reg <= addr_ok && hwrite;
      rd_pend_reg <= addr_ok && !hwrite;
      if (addr_ok)
      begin
        wr_addr_reg <= {haddr[7:2], 2'b00};
        rd_addr_reg <= {haddr[7:2], 2'b00};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data. The word is taken at the address phase from the decoded offset,
  // so it stands from a flop for the whole data phase with no wait state.
  // The cost: a register that changes during that data phase reads old.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (clk_en && addr_ok && !hwrite)
      hrdata <= rd_mux;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mailbox registers.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      flash_config_reg    <= `FSPTR_CFG_RESET;
      flash_command_reg   <= 8'h00;
      flash_addr_low_reg  <= 8'h00;
      flash_addr_high_reg <= 8'h00;
      flash_data_reg      <= 8'h00;
      context_reg         <= 2'b00;
    end
    else if (clk_en && wr_pend_reg)
    begin
      case (wr_addr_reg)
        `FSPTR_OFF_CONFIG:    flash_config_reg <= wdat & `FSPTR_CFG_WMASK;
        `FSPTR_OFF_COMMAND:   flash_command_reg <= wdat;
        `FSPTR_OFF_ADDR_LOW:  flash_addr_low_reg <= busy ? flash_addr_low_reg : wdat;
        `FSPTR_OFF_ADDR_HIGH: flash_addr_high_reg <= busy ? flash_addr_high_reg : wdat;
        `FSPTR_OFF_DATA:      flash_data_reg <= busy ? flash_data_reg : wdat;
        `FSPTR_OFF_CONTEXT:   context_reg <= busy ? context_reg : wdat[1:0];
        default:              flash_config_reg <= flash_config_reg;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Operation sequencer. All timing counts run on hclk; the internal
  // oscillator is only enabled, never used as a clock here.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg      <= ST_IDLE;
      count_reg      <= 8'h00;
      osc_enable     <= 1'b0;
      flash_op_start <= 1'b0;
      flash_op_block <= 1'b0;
      flash_op_addr  <= 16'h0000;
      flash_op_data  <= 8'h00;
      flash_op_cmd   <= 7'h00;
      fetch_block1   <= 1'b0;
    end
    else if (clk_en)
    begin
      fetch_block1   <= fetch_b1_next;
      flash_op_start <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (go)
          begin
            state_reg      <= ST_START;
            count_reg      <= {4'h0, `FSPTR_OSC_START_CYC};
            osc_enable     <= 1'b1;
            flash_op_block <= res_block;
            flash_op_addr  <= tgt_addr;
            flash_op_data  <= flash_data_reg;
            flash_op_cmd   <= wdat[6:0];
          end
        end
        ST_START:
        begin
          if (count_reg == 8'h01)
          begin
            state_reg      <= ST_RUN;
            count_reg      <= `FSPTR_OP_CYC;
            flash_op_start <= 1'b1;
          end
          else
            count_reg <= count_reg - 8'h01;
        end
        ST_RUN:
        begin
          if (flash_op_done)
          begin
            state_reg  <= ST_STOP;
            count_reg  <= {4'h0, `FSPTR_OSC_STOP_CYC};
            osc_enable <= 1'b0;
          end
        end
        ST_STOP:
        begin
          if (count_reg == 8'h01)
          begin
            state_reg <= ST_IDLE;
          end
          else
            count_reg <= count_reg - 8'h01;
        end
        default:
        begin
          state_reg  <= ST_IDLE;
          osc_enable <= 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Result word. A refused command is complete at once; an accepted one
  // reports done only once the oscillator has been shut down again, so
  // software polling done never races the oscillator stop.
  wire op_finish = (state_reg == ST_STOP) && (count_reg == 8'h01);
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      result_reg <= 32'h00000000;
    else if (clk_en)
    begin
      if (launch)
        result_reg <= {8'h00, tgt_addr, 5'h00, res_block, !go, !go};
      else if (op_finish)
        result_reg[`FSPTR_RES_DONE_BIT] <= 1'b1;
    end
  end

endmodule

// ---- verification/flash_self_program_target_resolver_bench.sv ----
/* Self-checking bench for the flash target resolver.
   Assumes the design, its bound checker and the flash array model. */
module flash_self_program_target_resolver_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        ea = 1'b1;
  logic        slow = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] fetch_pc = 16'h0;
  logic [2:0]  lock_bits = 3'b000;
  logic [31:0] hrdata, rdv, cap;
  logic        hreadyout, hresp, done, osc, start, blk, fblk1;
  logic [15:0] op_addr;
  logic [7:0]  op_data;
  logic [6:0]  op_cmd;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          starts = 0;
  localparam logic [25:0] CASES [12] = '{
    {3'd0, 3'd4, 2'd0, 2'd2, 16'h3000}, {3'd0, 3'd4, 2'd0, 2'd1, 16'h0100},
    {3'd0, 3'd4, 2'd2, 2'd0, 16'hFFFF}, {3'd0, 3'd5, 2'd0, 2'd2, 16'h2000},
    {3'd0, 3'd6, 2'd0, 2'd1, 16'h1FFF}, {3'd0, 3'd0, 2'd1, 2'd0, 16'h2000},
    {3'd0, 3'd0, 2'd1, 2'd1, 16'h1FFF}, {3'd0, 3'd3, 2'd1, 2'd0, 16'h0000},
    {3'd7, 3'd4, 2'd0, 2'd2, 16'h0100}, {3'd6, 3'd4, 2'd0, 2'd2, 16'h0100},
    {3'd6, 3'd4, 2'd2, 2'd0, 16'h4000}, {3'd2, 3'd4, 2'd0, 2'd1, 16'h0100}};
////////////////////////////////////////////////////////////
  fsptr_resolver dut (.hclk, .hresetn, .clk_en(1'b1), .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .external_access_pin(ea), .fetch_pc, .lock_bits, .flash_op_done(done), .osc_enable(osc),
    .flash_op_start(start), .flash_op_block(blk), .flash_op_addr(op_addr),
    .flash_op_data(op_data), .flash_op_cmd(op_cmd), .fetch_block1(fblk1));
  fsptr_flash_model array (.hclk, .hresetn, .slow, .flash_op_start(start), .flash_op_done(done));
  always #10 hclk = ~hclk;
  always @(posedge hclk)
    if (start === 1'b1)
    begin
      starts <= starts + 1;
      cap <= {op_cmd, op_data, op_addr, blk};
    end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task stop_test;
    if (num_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  task go;
    xfer(1'b1, 8'h04, 32'h0E);
    do xfer(1'b0, 8'h14, 32'h0); while (rdv[2] !== 1'b0);
    chk(osc, 1'b0);
    xfer(1'b0, 8'h1C, 32'h0);
  endtask
  task issue(input logic [1:0] ctx, input logic [15:0] tgt);
    xfer(1'b1, 8'h18, {30'h0, ctx});
    xfer(1'b1, 8'h08, {24'h0, tgt[7:0]});
    xfer(1'b1, 8'h0C, {24'h0, tgt[15:8]});
    xfer(1'b1, 8'h10, 32'h5A); // Target treated as erased.
    go;
  endtask
  task t_regs;
    lock_bits <= 3'b101;
    xfer(1'b0, 8'h00, 32'h0);
    chk(rdv, 32'h0);
    xfer(1'b1, 8'h00, 32'hFFFFFFFF);
    xfer(1'b0, 8'h00, 32'h0);
    chk(rdv, 32'h43);
    xfer(1'b0, 8'h20, 32'h0);
    chk(rdv, 32'h0);
    xfer(1'b0, 8'h14, 32'h0);
    chk(rdv[7:5], 3'b101);
    xfer(1'b1, 8'h00, 32'h0);
  endtask
  task t_off;
    int n;
    n = starts;
    lock_bits <= 3'b000;
    issue(2'd0, 16'h0100);
    chk(starts - n, 32'h0);
  endtask
  task t_resolve;
    logic [25:0] c;
    int n;
    for (int i = 0; i < 12; i++)
    begin
      c = CASES[i];
      lock_bits <= c[25:23];
      ea <= c[22];
      fetch_pc <= c[15:0];
      xfer(1'b1, 8'h00, {24'h0, 2'b01, 4'h0, c[21:20]});
      n = starts;
      issue(c[19:18], c[15:0]); // Own-block targets only probe refusal.
      chk(rdv[1], c[17]);
      chk(starts - n, {31'h0, ~c[17]});
      if (!c[17])
      begin
        chk(rdv[2], c[16]);
        chk(cap, {7'h0E, 8'h5A, c[15:0], c[16]});
      end
      if (c[22])
        chk(fblk1, c[21:20] == 2'd0 && c[15:0] < 16'h2000);
    end
  endtask
  task t_busy;
    int n;
    n = starts;
    lock_bits <= 3'b000;
    slow <= 1'b1;
    xfer(1'b1, 8'h18, 32'h2);
    xfer(1'b1, 8'h04, 32'h0E);
    xfer(1'b1, 8'h08, 32'h77);
    xfer(1'b0, 8'h14, 32'h0);
    chk(rdv[2], 1'b1);
    go;
    chk(starts - n, 32'h1);
    chk(cap[16:0], {16'h0100, 1'b0});
  endtask
  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_off;
    t_resolve;
    t_busy;
    stop_test;
  end
  initial
  begin
    #400000;
    num_errors++;
    stop_test;
  end
endmodule

// ---- verification/fsptr_asserts.sv ----
/* Port checker for the flash target resolver.
   Assumes one clock domain, low-active hresetn and a bind to fsptr_resolver. */
module fsptr_asserts (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [2:0]  lock_bits,
  input wire logic        flash_op_done,
  input wire logic        osc_enable,
  input wire logic        flash_op_start,
  input wire logic        flash_op_block,
  input wire logic [15:0] flash_op_addr
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
////////////////////////////////////////////////////////////
  property p_okay;
    !hresp && hreadyout;
  endproperty
  a_okay: assert property (p_okay) else $error("bus answer wrong");
  property p_osc_on;
    flash_op_start |-> osc_enable;
  endproperty
  a_osc_on: assert property (p_osc_on) else $error("start without osc");
  property p_warm;
    $rose(osc_enable) |-> !flash_op_start [*3] ##[1:3] flash_op_start;
  endproperty
  a_warm: assert property (p_warm) else $error("osc warm-up wrong");
  property p_pulse;
    flash_op_start |=> !flash_op_start;
  endproperty
  a_pulse: assert property (p_pulse) else $error("start too long");
  property p_hold;
    flash_op_start |=> $stable(flash_op_block) && $stable(flash_op_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("target moved");
  property p_osc_off;
    flash_op_done && !flash_op_start |-> ##[1:4] !osc_enable;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("osc left on");
  property p_low;
    flash_op_start && flash_op_block |-> flash_op_addr < 16'h2000;
  endproperty
  a_low: assert property (p_low) else $error("block 1 above 8K");
  property p_lock;
    flash_op_start |-> !(lock_bits inside {3'b100, 3'b011, 3'b101, 3'b111});
  endproperty
  a_lock: assert property (p_lock) else $error("locked op ran");
  property p_lock1;
    flash_op_start && (lock_bits inside {3'b110, 3'b001}) |-> !flash_op_block;
  endproperty
  a_lock1: assert property (p_lock1) else $error("hard block 1 written");
endmodule
bind fsptr_resolver fsptr_asserts chk_i (.hclk, .hresetn, .hreadyout, .hresp, .lock_bits,
  .flash_op_done, .osc_enable, .flash_op_start, .flash_op_block, .flash_op_addr);

// ---- verification/fsptr_flash_model.sv ----
/* Flash array model answering each operation with a one-cycle done.
   Assumes the resolver's start pulse and clock. */
module fsptr_flash_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic slow,
  input wire logic flash_op_start,
  output logic     flash_op_done
);
  logic [5:0] cnt;
////////////////////////////////////////////////////////////
  // A slow array keeps the controller busy long enough to probe the writes it ignores while busy.
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      cnt <= 6'd0;
    else if (flash_op_start)
      cnt <= slow ? 6'd40 : 6'd2;
    else if (cnt != 6'd0)
      cnt <= cnt - 6'd1;
  assign flash_op_done = (cnt == 6'd1);
endmodule
